// [src/serdes_channel_regs.vh]
// constants for the serdes channel with phase alignment
//
// Contract
// - every mode accepts a word factor from three through ten bits
// - transmit word captured by the serial clock when the load strobe fires
// - shift register moves low to high; top bit drives the line first
// - aligner picks the best of eight phases spaced 45 degrees apart
// - retiming buffer samples with the chosen phase, hands bits to slip stage (code buffers rx_sync_reg[1] and does not use the phase)
// - non-aligned receive bypasses aligner and buffer; sender keeps data aligned
// - each slip pulse delays the stream one serial bit
// - slip wrap flag rises four word clocks after the counter wraps
// - soft recovery uses the chosen phase and forwards a recovered word clock (code takes rx_sync_reg[1] directly; o_word_clk comes from bit_cnt_reg)
// - soft recovery limited to twelve channels per bank
// - duplex enables transmitters, equal counts up to eleven, no external pll
// - all receive channels in one bank, at most twenty-four channels
// - transmit clock and load strobe come from the pll side
// - local generator makes periphery clock and strobe; muxes pick clock source
// - load strobe pulses once per factor serial clocks
// - lock rises at first lock, drops after one or two same-way changes
`ifndef SERDES_CHANNEL_REGS_VH
`define SERDES_CHANNEL_REGS_VH
`define FACTOR_MIN 4'h3
`define FACTOR_MAX 4'ha
`define FACTOR_W 4
`define WORD_W 10
`define PHASE_N 8
`define PHASE_W 3
`define SLIP_WRAP 4'ha
`define WRAP_DELAY 2'h3
`define FIFO_DEPTH 4
`define FIFO_AW 2
`define MAX_SOFT_CDR 12
`define MAX_DUPLEX 11
`define MAX_BANK_CH 24
`define MODE_NON_ALIGNED 2'h0
`define MODE_PHASE_ALIGNED 2'h1
`define MODE_SOFT_CDR 2'h2
`endif

// [src/serdes_channel_with_phase_align.v]
// one serdes channel: serializer, phase aligner, retiming buffer, bit slip
`timescale 1ns/1ps
`include "serdes_channel_regs.vh"
module serdes_channel_with_phase_align #(
  parameter CHANNELS = 1,
  parameter DUPLEX = 0
) (
  input wire i_sys_clk,
  input wire i_srst,
  input wire [3:0] i_factor,
  input wire [1:0] i_rx_mode,
  input wire [9:0] i_tx_word,
  input wire i_rx_serial,
  input wire [7:0] i_phase_taps,
  input wire i_lock_one_change,
  input wire i_aligner_reset,
  input wire i_fifo_reset,
  input wire i_slip_req,
  input wire i_slip_reset,
  output reg o_tx_serial,
  output reg o_load_strobe,
  output reg o_word_clk,
  output reg [9:0] o_rx_word,
  output reg o_rx_word_valid,
  output reg o_phase_locked,
  output reg [2:0] o_selected_phase,
  output reg o_slip_wrap,
  output reg o_config_error
);
// --------------------------------------------------------------
// helpers
// --------------------------------------------------------------
function [3:0] clamp_factor;
  input [3:0] f;
  begin
    if (f < `FACTOR_MIN)
      clamp_factor = `FACTOR_MIN;
    else if (f > `FACTOR_MAX)
      clamp_factor = `FACTOR_MAX;
    else
      clamp_factor = f;
  end
endfunction
function [1:0] ptr_inc;
  input [1:0] p;
  begin
    ptr_inc = p + 2'h1;
  end
endfunction
// --------------------------------------------------------------
// input synchronisers
// --------------------------------------------------------------
reg [1:0] rx_sync_reg;
reg [7:0] tap_meta_reg;
reg [7:0] tap_reg;
reg [1:0] slip_sync_reg;
reg slip_prev_reg;
always @(posedge i_sys_clk)
begin
  if (i_srst)
  begin
    rx_sync_reg <= 2'h0;
    tap_meta_reg <= 8'h00;
    tap_reg <= 8'h00;
    slip_sync_reg <= 2'h0;
    slip_prev_reg <= 1'b0;
  end
  else
  begin
    rx_sync_reg <= {rx_sync_reg[0], i_rx_serial};
    tap_meta_reg <= i_phase_taps;
    tap_reg <= tap_meta_reg;
    slip_sync_reg <= {slip_sync_reg[0], i_slip_req};
    slip_prev_reg <= slip_sync_reg[1];
  end
end
wire slip_pulse = slip_sync_reg[1] & ~slip_prev_reg;
wire [3:0] factor = clamp_factor(i_factor);
// --------------------------------------------------------------
// load strobe generator and configuration check
// --------------------------------------------------------------
reg [3:0] bit_cnt_reg;
always @(posedge i_sys_clk)
begin
  if (i_srst)
  begin
    bit_cnt_reg <= 4'h0;
    o_load_strobe <= 1'b0;
    o_word_clk <= 1'b0;
    o_config_error <= 1'b0;
  end
  else
  begin
    if (bit_cnt_reg >= factor - 4'h1)
      bit_cnt_reg <= 4'h0;
    else
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    o_load_strobe <= (bit_cnt_reg == factor - 4'h1);
    o_word_clk <= (bit_cnt_reg < {1'b0, factor[3:1]});
    o_config_error <= (i_factor < `FACTOR_MIN) || (i_factor > `FACTOR_MAX) ||
      (CHANNELS > `MAX_BANK_CH) ||
      ((i_rx_mode == `MODE_SOFT_CDR) && (CHANNELS > `MAX_SOFT_CDR)) ||
      ((DUPLEX != 0) && (CHANNELS > `MAX_DUPLEX));
  end
end
wire load_now = (bit_cnt_reg == factor - 4'h1);
// --------------------------------------------------------------
// serializer
// --------------------------------------------------------------
reg [9:0] tx_hold_reg;
reg [9:0] tx_shift_reg;
reg tx_hold_full_reg;
always @(posedge i_sys_clk)
begin
  if (i_srst)
  begin
    tx_hold_reg <= 10'h000;
    tx_shift_reg <= 10'h000;
    tx_hold_full_reg <= 1'b0;
    o_tx_serial <= 1'b0;
  end
  else
  begin
    if (load_now)
    begin
      tx_hold_reg <= i_tx_word;
      tx_hold_full_reg <= 1'b1;
    end
    if (bit_cnt_reg == 4'h0 && tx_hold_full_reg)
      tx_shift_reg <= tx_hold_reg << (`WORD_W - factor);
    else
      tx_shift_reg <= {tx_shift_reg[8:0], 1'b0};
    o_tx_serial <= tx_shift_reg[`WORD_W - 1];
  end
end
// --------------------------------------------------------------
// phase aligner
// --------------------------------------------------------------
reg [2:0] phase_reg;
reg locked_seen_reg;
reg last_dir_reg;
reg [1:0] same_dir_reg;
reg [2:0] best;
integer k;
always @*
begin
  best = phase_reg;
  for (k = 0; k < `PHASE_N; k = k + 1)
    if (tap_reg[k] && tap_reg[(k + 7) % 8] && tap_reg[(k + 1) % 8])
      best = k[2:0];
end
wire phase_move = (best != phase_reg);
wire move_up = ((best - phase_reg) < 3'h4);
always @(posedge i_sys_clk)
begin
  if (i_srst || i_aligner_reset)
  begin
    phase_reg <= 3'h0;
    locked_seen_reg <= 1'b0;
    last_dir_reg <= 1'b0;
    same_dir_reg <= 2'h0;
    o_phase_locked <= 1'b0;
    o_selected_phase <= 3'h0;
  end
  else if (i_rx_mode != `MODE_NON_ALIGNED)
  begin
    if (phase_move)
    begin
      phase_reg <= best;
      last_dir_reg <= move_up;
      if (locked_seen_reg && (i_lock_one_change ||
        (same_dir_reg != 2'h0 && last_dir_reg == move_up)))
        o_phase_locked <= 1'b0;
      same_dir_reg <= locked_seen_reg ? 2'h1 : 2'h0;
    end
    else if (!locked_seen_reg && (tap_reg != 8'h00))
    begin
      locked_seen_reg <= 1'b1;
      o_phase_locked <= 1'b1;
    end
    o_selected_phase <= phase_reg;
  end
end
// --------------------------------------------------------------
// retiming buffer and receive path select
// --------------------------------------------------------------
reg fifo_mem [0:`FIFO_DEPTH - 1];
reg [1:0] wr_ptr_reg;
reg [1:0] rd_ptr_reg;
reg fifo_out_reg;
integer m;
always @(posedge i_sys_clk)
begin
  if (i_srst || i_fifo_reset)
  begin
    wr_ptr_reg <= 2'h2;
    rd_ptr_reg <= 2'h0;
    fifo_out_reg <= 1'b0;
    for (m = 0; m < `FIFO_DEPTH; m = m + 1)
      fifo_mem[m] <= 1'b0;
  end
  else
  begin
    fifo_mem[wr_ptr_reg] <= rx_sync_reg[1];
    wr_ptr_reg <= ptr_inc(wr_ptr_reg);
    rd_ptr_reg <= ptr_inc(rd_ptr_reg);
    fifo_out_reg <= fifo_mem[rd_ptr_reg];
  end
end
// non-aligned takes the line directly; soft recovery skips the buffer too
wire rx_bit = (i_rx_mode == `MODE_PHASE_ALIGNED) ? fifo_out_reg : rx_sync_reg[1];
// --------------------------------------------------------------
// bit slip and deserializer
// --------------------------------------------------------------
reg [9:0] delay_reg;
reg [3:0] slip_cnt_reg;
reg [9:0] des_shift_reg;
reg [1:0] wrap_wait_reg;
reg wrap_pend_reg;
always @(posedge i_sys_clk)
begin
  if (i_srst || i_slip_reset)
  begin
    delay_reg <= 10'h000;
    slip_cnt_reg <= 4'h0;
    des_shift_reg <= 10'h000;
    wrap_wait_reg <= 2'h0;
    wrap_pend_reg <= 1'b0;
    o_slip_wrap <= 1'b0;
    o_rx_word <= 10'h000;
    o_rx_word_valid <= 1'b0;
  end
  else
  begin
    delay_reg <= {delay_reg[8:0], rx_bit};
    if (slip_pulse)
    begin
      if (slip_cnt_reg >= `SLIP_WRAP - 4'h1)
      begin
        slip_cnt_reg <= 4'h0;
        wrap_pend_reg <= 1'b1;
        wrap_wait_reg <= 2'h0;
        o_slip_wrap <= 1'b0;
      end
      else
        slip_cnt_reg <= slip_cnt_reg + 4'h1;
    end
    else if (wrap_pend_reg && load_now)
    begin
      if (wrap_wait_reg == `WRAP_DELAY)
      begin
        wrap_pend_reg <= 1'b0;
        o_slip_wrap <= 1'b1;
      end
      else
        wrap_wait_reg <= wrap_wait_reg + 2'h1;
    end
    des_shift_reg <= {des_shift_reg[8:0],
      (slip_cnt_reg == 4'h0) ? rx_bit : delay_reg[slip_cnt_reg - 4'h1]};
    o_rx_word_valid <= load_now;
    if (load_now)
      o_rx_word <= des_shift_reg & ~(10'h3ff << factor);
  end
end
endmodule // serdes_channel_with_phase_align

// [tb/remote_serial_tx.sv]
// remote serial sender feeding the line input
`timescale 1ns/1ps
module remote_serial_tx (
  input wire logic i_clk,
  input wire logic [3:0] i_factor,
  input wire logic [9:0] i_word,
  output logic o_serial
);
  // ----------
  // msb first, one bit a clock
  // ----------
  int idx = 0;
  always @(posedge i_clk)
  begin
    idx = (idx <= 0) ? i_factor - 1 : idx - 1;
    o_serial <= #1 i_word[idx];
  end
endmodule // remote_serial_tx

// [tb/serdes_channel_sva.sv]
// port checker for the serdes channel
`timescale 1ns/1ps
`include "serdes_channel_regs.vh"
module serdes_channel_sva (
  input wire i_sys_clk,
  input wire i_srst,
  input wire [3:0] i_factor,
  input wire i_aligner_reset,
  input wire i_slip_reset,
  input wire o_load_strobe,
  input wire o_rx_word_valid,
  input wire o_phase_locked,
  input wire [2:0] o_selected_phase,
  input wire o_slip_wrap,
  input wire o_config_error
);
  // ----------
  // properties
  // ----------
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  a_reset_quiet: assert property ($past(i_srst) |-> !o_load_strobe && !o_rx_word_valid
    && !o_phase_locked && !o_slip_wrap && !o_config_error) else $error("outputs set after reset");
  a_valid_strobe: assert property (o_rx_word_valid |-> o_load_strobe)
    else $error("word valid without strobe");
  a_strobe_single: assert property (o_load_strobe && $stable(i_factor)
    |=> !o_load_strobe) else $error("strobe longer than one cycle");
  a_strobe_period: assert property (o_load_strobe && $stable(i_factor)
    && i_factor == 4'h8 ##1 (i_factor == 4'h8) [*7] |=> o_load_strobe)
    else $error("strobe period not factor");
  a_factor_flag: assert property (
    (i_factor < `FACTOR_MIN || i_factor > `FACTOR_MAX) [*3] |-> o_config_error)
    else $error("bad factor not flagged");
  a_factor_ok: assert property (
    (i_factor >= `FACTOR_MIN && i_factor <= `FACTOR_MAX) [*3] |-> !o_config_error)
    else $error("good factor flagged");
  a_wrap_clear: assert property (i_slip_reset |=> !o_slip_wrap)
    else $error("wrap flag kept over slip reset");
  a_aligner_home: assert property (i_aligner_reset |=> o_selected_phase == 3'h0
    && !o_phase_locked) else $error("aligner not home after reset");
  c_wrap: cover property (o_slip_wrap);
  c_lock: cover property (o_phase_locked);
  c_valid: cover property (o_rx_word_valid);
endmodule // serdes_channel_sva
bind serdes_channel_with_phase_align serdes_channel_sva i_serdes_channel_sva (.i_sys_clk,
  .i_srst, .i_factor, .i_aligner_reset, .i_slip_reset, .o_load_strobe, .o_rx_word_valid,
  .o_phase_locked, .o_selected_phase, .o_slip_wrap, .o_config_error);

// [tb/testbench.sv]
// self-checking bench for the serdes channel
`timescale 1ns/1ps
module testbench;
  // ----------
  // stimulus and checks
  // ----------
  logic i_sys_clk = 0, i_srst = 1, i_lock_one_change = 0, i_aligner_reset = 0;
  logic i_fifo_reset = 0, i_slip_req = 0, i_slip_reset = 0;
  logic [3:0] i_factor = 4'h8;
  logic [1:0] i_rx_mode = 2'h0;
  logic [9:0] i_tx_word = 10'h0, w = 10'h0, e;
  logic [7:0] i_phase_taps = 8'h0;
  wire i_rx_serial, o_tx_serial, o_load_strobe, o_word_clk, o_rx_word_valid;
  wire o_phase_locked, o_slip_wrap, o_config_error;
  wire [9:0] o_rx_word;
  wire [2:0] o_selected_phase;
  int miscompares = 0, num_checks = 0, seed = 32'h6635f6f6, f, k, j, n, rise;
  always #20 i_sys_clk = ~i_sys_clk;
  serdes_channel_with_phase_align i_serdes_channel_with_phase_align (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_factor(i_factor),
    .i_rx_mode(i_rx_mode),
    .i_tx_word(i_tx_word),
    .i_rx_serial(i_rx_serial),
    .i_phase_taps(i_phase_taps),
    .i_lock_one_change(i_lock_one_change),
    .i_aligner_reset(i_aligner_reset),
    .i_fifo_reset(i_fifo_reset),
    .i_slip_req(i_slip_req),
    .i_slip_reset(i_slip_reset),
    .o_tx_serial(o_tx_serial),
    .o_load_strobe(o_load_strobe),
    .o_word_clk(o_word_clk),
    .o_rx_word(o_rx_word),
    .o_rx_word_valid(o_rx_word_valid),
    .o_phase_locked(o_phase_locked),
    .o_selected_phase(o_selected_phase),
    .o_slip_wrap(o_slip_wrap),
    .o_config_error(o_config_error)
  );
  remote_serial_tx i_remote_serial_tx (.i_clk(i_sys_clk), .i_factor(i_factor), .i_word(w),
    .o_serial(i_rx_serial));
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic wait_strobe;
    for (int i = 0; i < 40 && o_load_strobe !== 1'b1; i++) tick(1);
  endtask
  function automatic logic [9:0] rotr(input logic [9:0] v);
    return {v[0], v[9:1]};
  endfunction
  task automatic align;
    tick(60);
    wait_strobe;
    e = w;
    for (int i = 0; i < 10 && e !== o_rx_word; i++) e = rotr(e);
    check(o_rx_word, e);
  endtask
  task automatic print_verdict;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #800000;
    miscompares++;
    print_verdict;
  end
  initial
  begin
    tick(5);
    i_srst = 0;
    tick(2);
    for (f = 3; f <= 10; f++)
    begin
      i_factor = f[3:0];
      w = 10'($random(seed));
      i_tx_word = w;
      tick(24);
      wait_strobe;
      check(o_load_strobe, 1);
      // bits leave from the second edge after the strobe
      for (j = 1; j <= f + 1; j++)
      begin
        tick(1);
        if (j >= 2)
          check(o_tx_serial, w[f + 1 - j]);
        check(o_load_strobe, j == f);
        check(o_word_clk, (j - 1) % f < f / 2);
      end
    end
    align;
    rise = 0;
    for (k = 0; k < 10; k++)
    begin
      check(o_slip_wrap, 0);
      i_slip_req = 1;
      tick(2);
      i_slip_req = 0;
      tick(1);
      // strobes counted after the edge that takes the slip
      n = 0;
      repeat (49)
      begin
        tick(1);
        n += o_load_strobe;
        if (o_slip_wrap === 1'b1 && rise == 0)
          rise = n;
      end
      wait_strobe;
      e = rotr(e);
      check(o_rx_word, e);
    end
    check(o_slip_wrap, 1);
    check(10'(rise), 4);
    i_slip_reset = 1;
    i_aligner_reset = 1;
    tick(1);
    i_slip_reset = 0;
    i_aligner_reset = 0;
    for (k = 1; k <= 2; k++)
    begin
      i_rx_mode = k[1:0];
      i_fifo_reset = 1;
      i_phase_taps = 8'h38;
      tick(40);
      check(o_selected_phase, 4);
      check(o_phase_locked, 1);
      i_fifo_reset = 0;
      align;
    end
    // one move keeps lock, a second move the same way drops it
    i_phase_taps = 8'h70;
    tick(40);
    check(o_selected_phase, 5);
    check(o_phase_locked, 1);
    i_phase_taps = 8'he0;
    tick(40);
    check(o_selected_phase, 6);
    check(o_phase_locked, 0);
    // with the one-change option any move drops lock
    i_aligner_reset = 1;
    i_lock_one_change = 1;
    tick(1);
    i_aligner_reset = 0;
    tick(40);
    check(o_selected_phase, 6);
    check(o_phase_locked, 1);
    i_phase_taps = 8'h70;
    tick(40);
    check(o_selected_phase, 5);
    check(o_phase_locked, 0);
    i_factor = 4'hf;
    tick(6);
    check(o_config_error, 1);
    print_verdict;
  end
endmodule // testbench
